// File: hdl/papc_top.v
// Page access protection check with relocation and AXI4-Lite register slave
`timescale 1ns/1ps
`include "papc_regs.vh"

module papc_top #(
  parameter ADDR_W = 12
) (
  input  wire              ref_clk,
  input  wire              nrst,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Processor side
  input  wire              req_valid,
  input  wire [15:0]       virtual_addr,
  input  wire              req_write,
  input  wire              req_istream,
  input  wire              move_from_prev_instr_space,
  input  wire [15:0]       processor_status_word,
  input  wire              instr_done,
  output reg               resp_valid,
  output reg               resp_abort,
  output reg               trap_req,
  output wire [7:0]        trap_vector,
  // Memory side
  output reg               mem_valid,
  output reg               mem_write,
  output reg  [17:0]       phys_addr,
  // Interrupt
  output wire              irq
);

  localparam RGN_NONE  = 3'h0;
  localparam RGN_DESC  = 3'h1;
  localparam RGN_BASE  = 3'h2;
  localparam RGN_CTRL  = 3'h3;
  localparam RGN_STAT  = 3'h4;
  localparam RGN_MASK  = 3'h5;
  localparam RGN_FAULT = 3'h6;

  // Bus response codes
  localparam RESP_OKAY   = 2'h0;
  localparam RESP_SLVERR = 2'h2;

  integer i;

  // Register storage
  reg  [7:0]  desc_q [0:`PAPC_NUM_PAGES-1];
  reg  [11:0] base_q [0:`PAPC_NUM_PAGES-1];
  reg  [1:0]  ctrl_q;
  reg  [2:0]  stat_q;
  reg  [2:0]  stat_d;
  reg  [2:0]  mask_q;
  reg  [18:0] fault_q;
  reg         pend_q;

  // Check path
  wire [5:0]  sel_idx;
  wire        mode_illegal;
  wire        key_deny;
  wire        key_trap;
  wire [7:0]  cur_desc;
  wire        chk_abort;
  wire        chk_done;
  wire        set_w;
  wire        set_a;
  wire        trap_fire;
  wire [11:0] phys_hi;

  // Bus path
  wire        wr_fire;
  wire        rd_fire;
  wire [2:0]  wr_rgn;
  wire [2:0]  rd_rgn;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  reg  [31:0] wr_old;
  wire [31:0] wr_val;
  reg  [31:0] rd_val;
  reg  [7:0]  hw_desc;

  // Register map, byte addresses on the bus:
  //   0x000 + 4*idx  descriptor of page register idx (key, written-into, attention)
  //   0x100 + 4*idx  base field of page register idx
  //   0x200 control, 0x204 status (write one to clear), 0x208 mask, 0x20c last fault
  // idx = set*16 + data_space*8 + page, set 0 kernel, 1 supervisor, 2 user; any other address answers with a slave error
  // Region decode shared by the read and write channels
  function [2:0] rgn_of;
    input [ADDR_W-1:0] addr;
    begin
      rgn_of = RGN_NONE;
      if (addr[ADDR_W-1:8] == `PAPC_OFS_DESC >> 8) begin
        if (addr[7:2] < `PAPC_NUM_PAGES) rgn_of = RGN_DESC;
      end else if (addr[ADDR_W-1:8] == `PAPC_OFS_BASE >> 8) begin
        if (addr[7:2] < `PAPC_NUM_PAGES) rgn_of = RGN_BASE;
      end else if (addr == `PAPC_OFS_CTRL) begin
        rgn_of = RGN_CTRL;
      end else if (addr == `PAPC_OFS_STAT) begin
        rgn_of = RGN_STAT;
      end else if (addr == `PAPC_OFS_MASK) begin
        rgn_of = RGN_MASK;
      end else if (addr == `PAPC_OFS_FAULT) begin
        rgn_of = RGN_FAULT;
      end
    end
  endfunction

  // Byte-lane merge of a write into the old register contents
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      b;
    begin
      strb_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  // Index of the page register that serves this reference
  papc_page_sel u_sel (
    .processor_status_word      (processor_status_word),
    .virtual_addr               (virtual_addr),
    .req_istream                (req_istream),
    .move_from_prev_instr_space (move_from_prev_instr_space),
    .id_sep_en                  (ctrl_q[`PAPC_CTRL_IDSEP]),
    .page_idx                   (sel_idx),
    .mode_illegal               (mode_illegal)
  );

  assign cur_desc = desc_q[sel_idx];

  // Key decode of the selected descriptor
  papc_key_check u_key (
    .access_key (cur_desc[`PAPC_DESC_KEY_HI:`PAPC_DESC_KEY_LO]),
    .is_write   (req_write),
    .trap_en    (ctrl_q[`PAPC_CTRL_TRAPEN]),
    .deny       (key_deny),
    .want_trap  (key_trap)
  );

  // Abort wins over everything; a denied reference never reaches memory
  // Illegal mode indexes a kernel word, but the abort gates every flag update
  assign chk_abort = req_valid & (mode_illegal | key_deny);
  assign chk_done  = req_valid & ~chk_abort;
  assign set_w     = chk_done & req_write;
  assign set_a     = chk_done & key_trap;
  assign trap_fire = instr_done & (pend_q | set_a);
  assign trap_vector = `PAPC_VECTOR;

  // Upper twelve physical bits: base field plus block number
  assign phys_hi = base_q[sel_idx] + {5'h00, virtual_addr[12:6]};

  // Processor and memory outputs, one cycle after the request
  // The physical address holds between references, so memory sees a steady word
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
      resp_abort <= 1'b0;
      mem_valid  <= 1'b0;
      mem_write  <= 1'b0;
      phys_addr  <= 18'h00000;
    end else begin
      resp_valid <= req_valid;
      resp_abort <= chk_abort;
      mem_valid  <= chk_done;
      mem_write  <= req_write;
      if (req_valid) phys_addr <= {phys_hi, virtual_addr[5:0]};
    end
  end

  // Deferred statistical trap: held until the instruction ends
  // A trapping reference in the completing cycle itself fires at once
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q   <= 1'b0;
      trap_req <= 1'b0;
    end else begin
      trap_req <= trap_fire;
      if (instr_done) pend_q <= 1'b0;
      else if (set_a) pend_q <= 1'b1;
    end
  end

  // AXI write handshake: address and data are taken together
  // A pending response blocks the next write until the master collects it
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign wr_rgn  = rgn_of(s_axi_awaddr);
  assign wr_idx  = s_axi_awaddr[7:2];

  // Old contents of the target word, for byte-lane merging; status is write-one-clear
  // and the fault word is read-only, so both merge against zero
  always @* begin
    case (wr_rgn)
      RGN_DESC: wr_old = {24'h000000, desc_q[wr_idx]};
      RGN_BASE: wr_old = {20'h00000, base_q[wr_idx]};
      RGN_CTRL: wr_old = {30'h00000000, ctrl_q};
      RGN_MASK: wr_old = {29'h00000000, mask_q};
      default:  wr_old = 32'h00000000;
    endcase
  end
  assign wr_val = strb_merge(wr_old, s_axi_wdata, s_axi_wstrb);

  // Flag update merges with a software write to the same descriptor
  // Flags are applied last, so a clear racing an event never loses the event
  always @* begin
    hw_desc = cur_desc;
    if (wr_fire && wr_rgn == RGN_DESC && wr_idx == sel_idx) hw_desc = wr_val[7:0];
    if (set_w) hw_desc[`PAPC_DESC_W_BIT] = 1'b1;
    if (set_a) hw_desc[`PAPC_DESC_A_BIT] = 1'b1;
  end

  // Descriptor and base arrays; hardware flag setting wins over a clear
  // Every page starts non-resident, so nothing maps until software sets keys
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `PAPC_NUM_PAGES; i = i + 1) begin
        desc_q[i] <= `PAPC_RST_DESC;
        base_q[i] <= `PAPC_RST_BASE;
      end
    end else begin
      if (wr_fire && wr_rgn == RGN_DESC) desc_q[wr_idx] <= wr_val[7:0];
      if (wr_fire && wr_rgn == RGN_BASE) base_q[wr_idx] <= wr_val[11:0];
      if (set_w || set_a) desc_q[sel_idx] <= hw_desc;
    end
  end

  // Sticky events; a new event beats a write-one clear in the same cycle
  always @* begin
    stat_d = stat_q;
    if (wr_fire && wr_rgn == RGN_STAT) stat_d = stat_q & ~wr_val[2:0];
    if (chk_abort) stat_d[`PAPC_ST_ABORT] = 1'b1;
    if (trap_fire) stat_d[`PAPC_ST_TRAP] = 1'b1;
    if (req_valid && mode_illegal) stat_d[`PAPC_ST_ILLMODE] = 1'b1;
  end

  // Control, status and mask
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q  <= `PAPC_RST_CTRL;
      stat_q  <= `PAPC_RST_STAT;
      mask_q  <= `PAPC_RST_STAT;
    end else begin
      stat_q <= stat_d;
      if (wr_fire && wr_rgn == RGN_CTRL) ctrl_q <= wr_val[1:0];
      if (wr_fire && wr_rgn == RGN_MASK) mask_q <= wr_val[2:0];
    end
  end

  // Last aborted reference: direction, mode and address, kept for the handler
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_q <= 19'h00000;
    end else if (chk_abort) begin
      fault_q <= {req_write, processor_status_word[15:14], virtual_addr};
    end
  end

  assign irq = |(stat_q & mask_q);

  // Write response; unmapped addresses answer with a slave error
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_rgn == RGN_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  // One read outstanding: arready falls while the answer waits for rready
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_rgn  = rgn_of(s_axi_araddr);
  assign rd_idx  = s_axi_araddr[7:2];

  // Read data mux; unused upper bits read as zero
  always @* begin
    case (rd_rgn)
      RGN_DESC:  rd_val = {24'h000000, desc_q[rd_idx]};
      RGN_BASE:  rd_val = {20'h00000, base_q[rd_idx]};
      RGN_CTRL:  rd_val = {30'h00000000, ctrl_q};
      RGN_STAT:  rd_val = {29'h00000000, stat_q};
      RGN_MASK:  rd_val = {29'h00000000, mask_q};
      RGN_FAULT: rd_val = {13'h0000, fault_q};
      default:   rd_val = 32'h00000000;
    endcase
  end

  // Read data is sampled when the address is taken
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= (rd_rgn == RGN_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: hdl/papc_regs.vh
// Register offsets, field positions, reset values and key codes of the page check
`ifndef PAPC_REGS_VH
`define PAPC_REGS_VH

// Register byte offsets on the AXI4-Lite slave
`define PAPC_OFS_DESC      12'h000
`define PAPC_OFS_BASE      12'h100
`define PAPC_OFS_CTRL      12'h200
`define PAPC_OFS_STAT      12'h204
`define PAPC_OFS_MASK      12'h208
`define PAPC_OFS_FAULT     12'h20c

// Number of descriptor / base register pairs (3 modes x 2 spaces x 8 pages)
`define PAPC_NUM_PAGES     48

// Descriptor fields
`define PAPC_DESC_KEY_HI   2
`define PAPC_DESC_KEY_LO   0
`define PAPC_DESC_W_BIT    6
`define PAPC_DESC_A_BIT    7

// Control fields
`define PAPC_CTRL_IDSEP    0
`define PAPC_CTRL_TRAPEN   1

// Status and mask fields
`define PAPC_ST_ABORT      0
`define PAPC_ST_TRAP       1
`define PAPC_ST_ILLMODE    2

// Reset values
`define PAPC_RST_DESC      8'h00
`define PAPC_RST_BASE      12'h000
`define PAPC_RST_CTRL      2'h0
`define PAPC_RST_STAT      3'h0

// Access keys
`define PAPC_KEY_NONRES    3'h0
`define PAPC_KEY_TRAP_RD   3'h1
`define PAPC_KEY_RDONLY    3'h2
`define PAPC_KEY_TRAP_WR   3'h4
`define PAPC_KEY_TRAP_RW   3'h5
`define PAPC_KEY_FULL      3'h6

// Mode codes of status word bits 15:14
`define PAPC_MODE_KERNEL   2'h0
`define PAPC_MODE_SUPER    2'h1
`define PAPC_MODE_ILLEGAL  2'h2
`define PAPC_MODE_USER     2'h3

// Abort and trap vector, kernel data space 250 octal
`define PAPC_VECTOR        8'ha8

`endif

// File: hdl/papc_page_sel.v
// Page register index selection from mode, space and virtual address
`timescale 1ns/1ps
`include "papc_regs.vh"

module papc_page_sel (
  input  wire [15:0] processor_status_word,
  input  wire [15:0] virtual_addr,
  input  wire        req_istream,
  input  wire        move_from_prev_instr_space,
  input  wire        id_sep_en,
  output reg  [5:0]  page_idx,
  output wire        mode_illegal
);

  reg [1:0] mode_num;
  reg       space_d;

  // Mode 10 is never mapped; every reference under it aborts
  assign mode_illegal = (processor_status_word[15:14] == `PAPC_MODE_ILLEGAL);

  // Set number, subset and page within the subset
  always @* begin
    case (processor_status_word[15:14])
      `PAPC_MODE_KERNEL: mode_num = 2'h0;
      `PAPC_MODE_SUPER:  mode_num = 2'h1;
      `PAPC_MODE_USER:   mode_num = 2'h2;
      default:           mode_num = 2'h0;
    endcase
    // Data subset when separation is on and the reference is not code, or by the user override below
    space_d = id_sep_en & ~req_istream;
    // User reading previous user instruction space goes via data registers
    if (move_from_prev_instr_space && processor_status_word[15:12] == 4'hf) begin
      space_d = 1'b1;
    end
    page_idx = {mode_num, 4'h0} + {2'h0, space_d, virtual_addr[15:13]};
  end

endmodule

// File: hdl/papc_key_check.v
// Access key decode: abort and statistical trap decision for one reference
`timescale 1ns/1ps
`include "papc_regs.vh"

module papc_key_check (
  input  wire [2:0] access_key,
  input  wire       is_write,
  input  wire       trap_en,
  output reg        deny,
  output reg        want_trap
);

  // Trap keys grant full access; they only trap while trap logic is enabled
  always @* begin
    deny      = 1'b0;
    want_trap = 1'b0;
    case (access_key)
      `PAPC_KEY_NONRES: deny = 1'b1;
      `PAPC_KEY_RDONLY: deny = is_write;
      `PAPC_KEY_FULL:   deny = 1'b0;
      `PAPC_KEY_TRAP_RD: want_trap = trap_en & ~is_write;
      `PAPC_KEY_TRAP_WR: want_trap = trap_en & is_write;
      `PAPC_KEY_TRAP_RW: want_trap = trap_en;
      default:          deny = 1'b1;
    endcase
  end

endmodule

// File: verif/papc_chk.sv
// Checker of reference timing, abort gating and trap deferral at the page check ports
`timescale 1ns/1ps
module papc_chk (
  input logic        ref_clk,
  input logic        nrst,
  input logic        req_valid,
  input logic [15:0] virtual_addr,
  input logic        req_write,
  input logic [15:0] processor_status_word,
  input logic        instr_done,
  input logic        resp_valid,
  input logic        resp_abort,
  input logic        trap_req,
  input logic [7:0]  trap_vector,
  input logic        mem_valid,
  input logic        mem_write,
  input logic [17:0] phys_addr
);
  // One domain, so clock and reset are given once for all properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Answer comes exactly one cycle after each reference, never without one
  resp_lat_a: assert property (req_valid |=> resp_valid)
    else $error("reference not answered");
  resp_idle_a: assert property (!req_valid |=> !resp_valid)
    else $error("answer without reference");
  // Memory only sees references that were not aborted
  mem_gate_a: assert property (resp_valid |-> mem_valid == !resp_abort)
    else $error("memory strobe disagrees with abort");
  mem_only_a: assert property (mem_valid |-> resp_valid)
    else $error("memory strobe outside an answer");
  // Mode code 10 aborts whatever the descriptors hold
  bad_mode_a: assert property (req_valid && processor_status_word[15:14] == 2'h2
    |=> resp_abort && !mem_valid)
    else $error("illegal mode reference not aborted");
  // Offset within a block passes unchanged, direction follows the request
  low_bits_a: assert property (req_valid ##1 mem_valid |-> phys_addr[5:0] ==
    $past(virtual_addr[5:0]) && mem_write == $past(req_write))
    else $error("block offset or direction altered");
  // Traps only follow an instruction completion
  trap_defer_a: assert property (trap_req |-> $past(instr_done))
    else $error("trap before instruction completed");
  trap_vec_a: assert property (trap_req |-> trap_vector == 8'ha8)
    else $error("trap vector wrong");
endmodule

bind papc_top papc_chk papc_chk_inst (
  .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .virtual_addr(virtual_addr),
  .req_write(req_write), .processor_status_word(processor_status_word),
  .instr_done(instr_done), .resp_valid(resp_valid), .resp_abort(resp_abort),
  .trap_req(trap_req), .trap_vector(trap_vector), .mem_valid(mem_valid),
  .mem_write(mem_write), .phys_addr(phys_addr)
);

// File: verif/papc_cpu_model.sv
// Processor core model issuing references and instruction completions
`timescale 1ns/1ps
module papc_cpu_model (
  input  logic        ref_clk,
  output logic        req_valid,
  output logic [15:0] virtual_addr,
  output logic        req_write,
  output logic        req_istream,
  output logic        move_from_prev_instr_space,
  output logic [15:0] processor_status_word,
  output logic        instr_done
);
  // Idle at time zero
  initial begin
    req_valid = 1'b0;
    virtual_addr = 16'h0000;
    req_write = 1'b0;
    req_istream = 1'b0;
    move_from_prev_instr_space = 1'b0;
    processor_status_word = 16'h0000;
    instr_done = 1'b0;
  end
  // One reference; address flips once idle so a stale value never looks valid
  task automatic issue(input logic [15:0] psw, input logic [15:0] vaddr, input logic [2:0] kind);
    req_valid <= 1'b1;
    processor_status_word <= psw;
    virtual_addr <= vaddr;
    {req_write, req_istream, move_from_prev_instr_space} <= kind;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    virtual_addr <= ~vaddr;
    @(posedge ref_clk);
  endtask
  // Completion pulse of one cycle; called right after issue it comes two cycles after the reference
  task automatic finish_instr;
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

// File: verif/test_page_access_protection_check.sv
// Self-checking bench: setup, reference table, statistics flags, traps, interrupt
`timescale 1ns/1ps
`include "papc_regs.vh"
module test_page_access_protection_check;
  typedef struct packed {
    logic [15:0] psw;
    logic [15:0] vaddr;
    logic [3:0]  flg;
    logic [17:0] pa;
  } papc_row_t;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        req_valid, req_write, req_istream, prev_rd, instr_done;
  logic [15:0] virtual_addr, psw;
  logic        resp_valid, resp_abort, trap_req, mem_valid, mem_write, irq;
  logic [7:0]  trap_vector;
  logic [17:0] phys_addr;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp, wr_resp;
  int          n_errors = 0;
  int          tests_run = 0;
  // Ready lines held high: the bench always accepts answers at once
  papc_top papc_top_inst (
    .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .req_valid(req_valid),
    .virtual_addr(virtual_addr), .req_write(req_write), .req_istream(req_istream),
    .move_from_prev_instr_space(prev_rd), .processor_status_word(psw),
    .instr_done(instr_done), .resp_valid(resp_valid), .resp_abort(resp_abort),
    .trap_req(trap_req), .trap_vector(trap_vector), .mem_valid(mem_valid),
    .mem_write(mem_write), .phys_addr(phys_addr), .irq(irq)
  );
  papc_cpu_model papc_cpu_model_inst (
    .ref_clk(ref_clk), .req_valid(req_valid), .virtual_addr(virtual_addr),
    .req_write(req_write), .req_istream(req_istream), .move_from_prev_instr_space(prev_rd),
    .processor_status_word(psw), .instr_done(instr_done)
  );
  always #10 ref_clk = ~ref_clk;
  // Write: address and data offered together, held until taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_awready !== 1'b1) @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge ref_clk);
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    wr_resp = s_axi_bresp;
  endtask
  task automatic axr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_arready !== 1'b1) @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge ref_clk);
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Setup words {address, value}; rows {status, address, wr ist prev abort, physical}
  logic [23:0] setup [13] = '{24'h000006, 24'h100010, 24'h004002, 24'h00c003, 24'h010001,
    24'h014004, 24'h018005, 24'h040006, 24'h140020, 24'h080002, 24'h0a0006, 24'h1a0040,
    24'h200001};
  papc_row_t rows [14] = '{
    '{16'h0000, 16'h0044, 4'h4, 18'h00444}, '{16'h0000, 16'h0044, 4'hc, 18'h00444},
    '{16'h0000, 16'h2000, 4'h4, 18'h00000}, '{16'h0000, 16'h2000, 4'hd, 18'h00000},
    '{16'h0000, 16'h4000, 4'h5, 18'h00000}, '{16'h0000, 16'h4000, 4'hd, 18'h00000},
    '{16'h0000, 16'h6000, 4'h5, 18'h00000}, '{16'h0000, 16'h0044, 4'h1, 18'h00000},
    '{16'h4000, 16'h0044, 4'h4, 18'h00844}, '{16'h8000, 16'h0044, 4'h5, 18'h00000},
    '{16'hc000, 16'h0044, 4'h4, 18'h00044}, '{16'hc000, 16'h0044, 4'hd, 18'h00000},
    '{16'hf000, 16'h0044, 4'h6, 18'h01044}, '{16'hc000, 16'h0044, 4'h8, 18'h01044}};
  // Main sequence
  initial begin
    logic [2:0] pg;
    logic [5:0] trap_exp;
    trap_exp = 6'h39;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    axr(`PAPC_OFS_DESC);
    check("desc reset", rd_data, 32'h00000000);
    axr(`PAPC_OFS_CTRL);
    check("ctrl reset", rd_data, 32'h00000000);
    foreach (setup[i]) axw(setup[i][23:12], {20'h00000, setup[i][11:0]});
    foreach (rows[i]) begin
      papc_cpu_model_inst.issue(rows[i].psw, rows[i].vaddr, rows[i].flg[3:1]);
      check("abort", resp_abort, rows[i].flg[0]);
      check("answer", resp_valid, 1'b1);
      check("mem", mem_valid, !rows[i].flg[0]);
      check("dir", mem_write, rows[i].flg[3]);
      if (!rows[i].flg[0]) check("phys", phys_addr, rows[i].pa);
    end
    axr(12'h000);
    check("written page", rd_data, 32'h00000046);
    axr(12'h004);
    check("aborted write page", rd_data, 32'h00000002);
    // Last abort was the user write to the read-only page
    axr(`PAPC_OFS_FAULT);
    check("fault", rd_data, 32'h00070044);
    // Statistical traps: each trap key read then written
    axw(`PAPC_OFS_CTRL, 32'h00000003);
    for (int j = 0; j < 6; j++) begin
      pg = 3'(4 + j / 2);
      papc_cpu_model_inst.issue(16'h0000, {pg, 13'h0000}, {j[0], 2'h2});
      check("trap key abort", resp_abort, 1'b0);
      check("trap early", trap_req, 1'b0);
      papc_cpu_model_inst.finish_instr;
      check("trap", trap_req, trap_exp[j]);
    end
    check("vector", trap_vector, `PAPC_VECTOR);
    axr(12'h010);
    check("attention", rd_data, 32'h000000c1);
    // Interrupt raised only when unmasked, dropped by a one-write clear
    axr(`PAPC_OFS_STAT);
    check("status", rd_data, 32'h00000007);
    check("irq masked", irq, 1'b0);
    axw(`PAPC_OFS_MASK, 32'h00000002);
    check("irq on", irq, 1'b1);
    axw(`PAPC_OFS_STAT, 32'h00000002);
    check("irq clear", irq, 1'b0);
    axr(`PAPC_OFS_STAT);
    check("status clear", rd_data, 32'h00000005);
    axr(12'h300);
    check("unmapped read", rd_resp, 2'h2);
    axw(12'h300, 32'h00000001);
    check("unmapped write", wr_resp, 2'h2);
    // Mid-run reset: pages back to non-resident, events and interrupt gone
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check("irq reset", irq, 1'b0);
    axr(12'h000);
    check("desc rerun", rd_data, 32'h00000000);
    axr(`PAPC_OFS_STAT);
    check("status rerun", rd_data, 32'h00000000);
    papc_cpu_model_inst.issue(16'h0000, 16'h0044, 3'h4);
    check("abort rerun", resp_abort, 1'b1);
    check("mem rerun", mem_valid, 1'b0);
    wrap_up;
  end
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule
